// ---- opcc_clock_config.sv ----
// oscillator control, write guard and pll divider chain with lock detect
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module opcc_clock_config
	import opcc_pkg::*;
#(
	parameter logic [15:0] TRIM_RESET = RST_TRIM
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic special_mode,
	input wire logic oscillator_clock,
	input wire logic internal_rc_clock,
	input wire logic vco_clock,
	output opcc_ticks_t clk_ticks,
	output logic osc_enable,
	output logic osc_qualified,
	output logic bus_from_osc,
	output logic clock_monitor_reset,
	output logic lock_irq,
	output logic [15:0] rc_trim,
	output logic [7:0] factory_test
);
	// pin synchronisers: osc, rc, vco
	logic [2:0] pin_in;
	logic [2:0] s1, s2, s3, lvl, next_lvl, edge_tick;
	assign pin_in = {vco_clock, internal_rc_clock, oscillator_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			always_comb begin
				next_lvl[gi] = (s2[gi] == s3[gi]) ? s3[gi] : lvl[gi];
				edge_tick[gi] = next_lvl[gi] & ~lvl[gi];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1[gi] <= 1'b0;
					s2[gi] <= 1'b0;
					s3[gi] <= 1'b0;
					lvl[gi] <= 1'b0;
				end else begin
					s1[gi] <= pin_in[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					lvl[gi] <= next_lvl[gi];
				end
			end
		end
	endgenerate

	logic osc_edge, rc_edge, vco_edge;
	assign osc_edge = edge_tick[0];
	assign rc_edge = edge_tick[1];
	assign vco_edge = edge_tick[2];

	// register state
	logic [7:0] syn, reference_divider_r, test_r, flag_rd;
	logic [4:0] post_divider;
	logic [15:0] trim;
	opcc_osc_t osc;
	logic guard, pll_sel, lock_ie, lock, lock_if, qual;
	logic [7:0] next_syn, next_reference_divider, next_test;
	logic [4:0] next_post_divider;
	logic [15:0] next_trim;
	opcc_osc_t next_osc;
	logic next_guard, next_pll_sel, next_lock_ie, next_lock_if;
	logic [31:0] next_prdata;
	logic next_lock_irq;

	// apb decode; writes take effect on the access edge
	logic wr_en, rd_setup, hit;
	logic [11:0] idx;
	logic osc_wr;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign idx = {2'b00, paddr[ADDR_W-1:2]};
	assign pready = 1'b1;

	always_comb begin
		case (idx)
			IDX_SYN, IDX_REFERENCE_DIVIDER, IDX_POST_DIVIDER, IDX_CLKS, IDX_PLL,
			IDX_FLAG, IDX_TRIM, IDX_OSC, IDX_WRITE_GUARD_BIT, IDX_TEST: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~hit;
	assign osc_wr = wr_en & (idx == IDX_OSC) & ~guard & pll_sel; // [RL1]

	assign flag_rd = {3'b000, lock_if, lock, 2'b00, qual};

	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (idx)
				IDX_SYN: next_prdata = {24'h0, syn};
				IDX_REFERENCE_DIVIDER: next_prdata = {24'h0, reference_divider_r};
				IDX_POST_DIVIDER: next_prdata = {27'h0, post_divider};
				IDX_CLKS: next_prdata = {24'h0, pll_sel, 7'h00};
				IDX_PLL: next_prdata = {27'h0, lock_ie, 4'h0};
				IDX_FLAG: next_prdata = {24'h0, flag_rd};
				IDX_TRIM: next_prdata = {16'h0, trim};
				IDX_OSC: next_prdata = {24'h0, osc}; // [RL25]
				IDX_WRITE_GUARD_BIT: next_prdata = {31'h0, guard}; // [RL25]
				IDX_TEST: next_prdata = {24'h0, test_r};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	// qualification events that feed the clock select
	logic qual_fall;

	always_comb begin
		next_syn = syn;
		next_reference_divider = reference_divider_r;
		next_post_divider = post_divider;
		next_trim = trim;
		next_osc = osc;
		next_guard = guard;
		next_pll_sel = pll_sel;
		next_lock_ie = lock_ie;
		next_test = test_r;
		if (wr_en) begin
			case (idx)
				IDX_SYN: if (!guard) next_syn = pwdata[7:0]; // [RL12]
				IDX_REFERENCE_DIVIDER: if (!guard) begin // [RL12]
					next_reference_divider = {pwdata[7:6], 2'b00, pwdata[3:0]};
				end
				IDX_POST_DIVIDER: next_post_divider = pwdata[4:0];
				IDX_CLKS: if (!guard) begin // [RL12]
					// oscillator may drive the bus only once qualified
					if (pwdata[CLKS_PLL_CLOCK_SELECT] || qual) begin // [RL6]
						next_pll_sel = pwdata[CLKS_PLL_CLOCK_SELECT];
					end
				end
				IDX_PLL: if (!guard) next_lock_ie = pwdata[PLL_LOCK_IRQ_ENABLE]; // [RL12]
				IDX_TRIM: if (!guard) next_trim = pwdata[15:0]; // [RL12]
				IDX_OSC: if (osc_wr) begin // [RL1]
					next_osc = pwdata[7:0];
					next_osc.unused = 1'b0; // [RL25]
				end
				IDX_WRITE_GUARD_BIT: next_guard = (pwdata[7:0] != GUARD_KEY); // [RL11]
				IDX_TEST: if (special_mode) next_test = pwdata[7:0]; // [RL13]
				default: next_guard = guard;
			endcase
		end
		// hardware return to pll wins over a software write only while the oscillator is already selected
		if (qual_fall && !pll_sel) begin
			next_pll_sel = 1'b1; // [RL23]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syn <= RST_SYN;
			reference_divider_r <= RST_REFERENCE_DIVIDER;
			post_divider <= RST_POST_DIVIDER; // [RL24]
			trim <= TRIM_RESET;
			osc <= '0;
			guard <= 1'b0;
			pll_sel <= 1'b1;
			lock_ie <= 1'b0;
			test_r <= RST_TEST;
			prdata <= 32'h0;
		end else begin
			syn <= next_syn;
			reference_divider_r <= next_reference_divider;
			post_divider <= next_post_divider;
			trim <= next_trim;
			osc <= next_osc;
			guard <= next_guard;
			pll_sel <= next_pll_sel;
			lock_ie <= next_lock_ie;
			test_r <= next_test;
			prdata <= next_prdata;
		end
	end

	// divider chain
	logic trim_wr, cfg_clr;
	logic ref_tick, fb_tick, pll_tick, bus_div_tick;
	assign trim_wr = wr_en & (idx == IDX_TRIM) & ~guard & pll_sel;
	assign cfg_clr = osc_wr | trim_wr;

	opcc_tick_div #(.W(4)) u_ref (
		.pclk(pclk),
		.presetn(presetn),
		.clr(cfg_clr),
		.tick_in(osc.enable ? osc_edge : rc_edge), // [RL4]
		.div(osc.enable ? reference_divider_r[3:0] : 4'h0), // [RL14]
		.tick_out(ref_tick)
	);

	// vco runs at twice reference times multiplier plus one, so the
	// feedback tick is vco over multiplier plus one
	opcc_tick_div #(.W(6)) u_fb (
		.pclk(pclk),
		.presetn(presetn),
		.clr(cfg_clr),
		.tick_in(vco_edge),
		.div(syn[5:0]), // [RL15] [RL18]
		.tick_out(fb_tick)
	);

	opcc_tick_div #(.W(5)) u_post (
		.pclk(pclk),
		.presetn(presetn),
		.clr(cfg_clr),
		.tick_in(vco_edge),
		.div(lock ? post_divider : UNLOCKED_DIV), // [RL16]
		.tick_out(pll_tick)
	);

	opcc_tick_div #(.W(1)) u_bus (
		.pclk(pclk),
		.presetn(presetn),
		.clr(cfg_clr),
		.tick_in(pll_tick),
		.div(1'b1), // [RL17]
		.tick_out(bus_div_tick)
	);

	// lock detector: count feedback ticks over a window of reference
	// ticks; expect two per reference tick
	localparam logic [7:0] EXPECT = 8'(2 * LOCK_WIN);
	logic [4:0] win_cnt, next_win_cnt;
	logic [7:0] fb_cnt, next_fb_cnt, fb_total, diff;
	logic next_lock;

	always_comb begin
		next_win_cnt = win_cnt;
		next_fb_cnt = fb_cnt;
		next_lock = lock;
		fb_total = fb_cnt + {7'h00, fb_tick};
		diff = (fb_total > EXPECT) ? fb_total - EXPECT : EXPECT - fb_total;
		if (fb_tick && fb_cnt != 8'hFF) begin
			next_fb_cnt = fb_total;
		end
		if (ref_tick) begin
			if (win_cnt == 5'(LOCK_WIN - 1)) begin // [RL18]
				next_win_cnt = '0;
				next_fb_cnt = '0;
				if (!lock && diff <= 8'(LOCK_TOL)) begin
					next_lock = 1'b1; // [RL19]
				end else if (lock && diff > 8'(UNL_TOL)) begin
					next_lock = 1'b0; // [RL19]
				end
			end else begin
				next_win_cnt = win_cnt + 1'b1;
			end
		end
		if (cfg_clr) begin
			next_lock = 1'b0; // [RL2]
			next_win_cnt = '0;
			next_fb_cnt = '0;
		end
	end

	// lock interrupt flag, cleared by writing one; a toggle wins
	always_comb begin
		next_lock_if = lock_if;
		if (wr_en && idx == IDX_FLAG && pwdata[FLAG_LOCKIF]) begin
			next_lock_if = 1'b0;
		end
		if (next_lock != lock) begin
			next_lock_if = 1'b1; // [RL20]
		end
		next_lock_irq = next_lock_if & next_lock_ie; // [RL20]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt <= '0;
			fb_cnt <= '0;
			lock <= 1'b0;
			lock_if <= 1'b0;
			lock_irq <= 1'b0;
		end else begin
			win_cnt <= next_win_cnt;
			fb_cnt <= next_fb_cnt;
			lock <= next_lock;
			lock_if <= next_lock_if;
			lock_irq <= next_lock_irq;
		end
	end

	// oscillator filter, qualification and clock monitor
	logic [7:0] period, next_period;
	logic [5:0] exp_per;
	logic per_ok, filt_on;
	logic [3:0] good_cnt, next_good_cnt;
	logic [9:0] mon_cnt, next_mon_cnt;
	logic next_qual, next_cm;

	assign filt_on = (osc.ratio != 5'h00); // [RL10]
	assign exp_per = {osc.ratio, 1'b0};

	always_comb begin
		// narrow window demands the exact period, wide allows one either way
		if (osc.window_wide) begin // [RL8]
			per_ok = (period + 8'h01 >= {2'b00, exp_per}) &&
				(period <= {2'b00, exp_per} + 8'h01);
		end else begin
			per_ok = (period == {2'b00, exp_per}); // [RL8]
		end
	end

	always_comb begin
		next_period = period;
		next_good_cnt = good_cnt;
		next_qual = qual;
		next_mon_cnt = mon_cnt;
		next_cm = 1'b0;
		if (vco_edge && period != 8'hFF) begin
			next_period = period + 8'h01;
		end
		if (!osc.enable) begin
			next_qual = 1'b0;
			next_good_cnt = '0;
			next_mon_cnt = '0;
		end else if (osc_edge) begin
			next_period = '0;
			next_mon_cnt = '0;
			if (filt_on && (!per_ok || !lock)) begin
				next_good_cnt = '0; // [RL10]
				next_qual = 1'b0;
			end else if (good_cnt == 4'(QUAL_EDGES - 1)) begin
				next_qual = 1'b1; // [RL6]
			end else begin
				next_good_cnt = good_cnt + 4'h1;
			end
		end else if (mon_cnt == 10'(MON_CYCLES - 1)) begin
			// one pulse per loss; the count holds until an edge returns
			next_cm = 1'b1; // [RL5]
			next_mon_cnt = mon_cnt + 10'h001;
			next_qual = 1'b0;
			next_good_cnt = '0;
		end else if (mon_cnt < 10'(MON_CYCLES)) begin
			next_mon_cnt = mon_cnt + 10'h001;
		end
		// losing lock loses the qualification that depends on it
		if (lock && !next_lock) begin
			next_qual = 1'b0;
			next_good_cnt = '0;
		end
		if (cfg_clr) begin
			next_qual = 1'b0; // [RL2]
			next_good_cnt = '0;
		end
	end

	assign qual_fall = qual & ~next_qual;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period <= '0;
			good_cnt <= '0;
			qual <= 1'b0;
			mon_cnt <= '0;
			clock_monitor_reset <= 1'b0;
		end else begin
			period <= next_period;
			good_cnt <= next_good_cnt;
			qual <= next_qual;
			mon_cnt <= next_mon_cnt;
			clock_monitor_reset <= next_cm;
		end
	end

	// outputs
	assign clk_ticks.ref_tick = ref_tick;
	assign clk_ticks.fb_tick = fb_tick;
	assign clk_ticks.vco_tick = vco_edge;
	assign clk_ticks.pll_tick = pll_tick;
	assign clk_ticks.bus_tick = pll_sel ? bus_div_tick : osc_edge; // [RL17]
	assign osc_enable = osc.enable; // [RL4]
	assign osc_qualified = qual; // [RL6]
	assign bus_from_osc = ~pll_sel;
	assign rc_trim = trim;
	assign factory_test = test_r;
endmodule : opcc_clock_config

// ---- opcc_clock_config_props.sv ----
// port assertions for the oscillator and pll clock config block
`timescale 1ns/1ps
module opcc_props
	import opcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic special_mode,
	input wire logic oscillator_clock,
	input wire logic internal_rc_clock,
	input wire logic vco_clock,
	input wire opcc_ticks_t clk_ticks,
	input wire logic osc_enable,
	input wire logic osc_qualified,
	input wire logic bus_from_osc,
	input wire logic clock_monitor_reset,
	input wire logic lock_irq,
	input wire logic [15:0] rc_trim,
	input wire logic [7:0] factory_test
);
	logic wr;
	logic guard;
	logic next_guard;
	assign wr = psel && penable && pwrite;
	function automatic logic at(input logic [11:0] i);
		return wr && {2'b00, paddr[11:2]} == i;
	endfunction : at
	// own copy of the guard, rebuilt from the bus traffic
	always_comb begin
		next_guard = guard;
		if (at(IDX_WRITE_GUARD_BIT))
			next_guard = pwdata[7:0] != GUARD_KEY;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			guard <= 1'b0;
		else
			guard <= next_guard;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_guard_osc: assert property (at(IDX_OSC) && guard |=> $stable(osc_enable))
		else $error("guarded oscillator write took effect");
	a_guard_trim: assert property (at(IDX_TRIM) && guard |=> $stable(rc_trim))
		else $error("guarded trim write took effect");
	a_osc_sel: assert property (at(IDX_OSC) && bus_from_osc |=> $stable(osc_enable))
		else $error("oscillator write taken while bus on oscillator");
	a_osc_take: assert property (at(IDX_OSC) && !guard && !bus_from_osc |=> osc_enable == $past(pwdata[7]))
		else $error("enable bit not taken from write");
	a_osc_clears: assert property (at(IDX_OSC) && !guard && !bus_from_osc |=> !osc_qualified)
		else $error("qualified flag kept after oscillator write");
	a_test_mode: assert property (at(IDX_TEST) && !special_mode |=> $stable(factory_test))
		else $error("test register written outside special mode");
	a_mon_enabled: assert property (clock_monitor_reset |-> $past(osc_enable))
		else $error("monitor reset with oscillator off");
	a_mon_pulse: assert property (clock_monitor_reset |=> !clock_monitor_reset)
		else $error("monitor reset longer than one cycle");
	a_qual_enabled: assert property (osc_qualified |-> osc_enable)
		else $error("qualified with oscillator off");
	a_sel_qual: assert property ($rose(bus_from_osc) |-> $past(osc_qualified))
		else $error("bus moved to unqualified oscillator");
	a_qual_loss: assert property ($fell(osc_qualified) && bus_from_osc |-> ##[0:2] !bus_from_osc)
		else $error("bus kept on oscillator after qualification loss");
	cover property (clock_monitor_reset);
	cover property (lock_irq);
	cover property (pslverr);
endmodule : opcc_props

bind opcc_clock_config opcc_props u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .special_mode,
	.oscillator_clock, .internal_rc_clock, .vco_clock, .clk_ticks,
	.osc_enable, .osc_qualified, .bus_from_osc, .clock_monitor_reset,
	.lock_irq, .rc_trim, .factory_test);

// ---- opcc_clock_config_tb_top.sv ----
// self-checking bench for the oscillator and pll clock config block
`timescale 1ns/1ps
module opcc_clock_config_tb_top
	import opcc_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, special_mode = 1'b0, osc_run = 1'b0;
	logic osc_pin = 1'b0, rc_pin = 1'b0, vco_pin = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, osc_enable, osc_qualified, bus_from_osc, err;
	logic clock_monitor_reset, lock_irq;
	logic [15:0] rc_trim;
	logic [7:0] factory_test;
	opcc_ticks_t clk_ticks;
	int num_errors = 0, num_checks = 0, cyc = 0, seed = 32'h962B3A88;
	int r, k;
	int n[6] = '{default: 0}, s[6], d[6];
	logic [11:0] ri[10] = '{IDX_SYN, IDX_REFERENCE_DIVIDER, IDX_POST_DIVIDER, IDX_CLKS,
		IDX_PLL, IDX_FLAG, IDX_TRIM, IDX_OSC, IDX_WRITE_GUARD_BIT, IDX_TEST};
	logic [31:0] rv[10] = '{RST_SYN, RST_REFERENCE_DIVIDER, RST_POST_DIVIDER, 32'h80,
		32'h0, 32'h0, RST_TRIM, 32'h0, 32'h0, RST_TEST};
	opcc_clock_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.special_mode(special_mode), .oscillator_clock(osc_pin),
		.internal_rc_clock(rc_pin), .vco_clock(vco_pin),
		.clk_ticks(clk_ticks), .osc_enable(osc_enable),
		.osc_qualified(osc_qualified), .bus_from_osc(bus_from_osc),
		.clock_monitor_reset(clock_monitor_reset), .lock_irq(lock_irq),
		.rc_trim(rc_trim), .factory_test(factory_test));
	always #50 pclk = ~pclk;
	// pin edges fall on falling pclk edges so sampling never races
	always #800 rc_pin = ~rc_pin;
	always #400 vco_pin = ~vco_pin;
	always #600 osc_pin = osc_run ? ~osc_pin : 1'b0;
	always @(posedge osc_pin) n[5]++;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		n[0] <= n[0] + clk_ticks.vco_tick;
		n[1] <= n[1] + clk_ticks.pll_tick;
		n[2] <= n[2] + clk_ticks.bus_tick;
		n[3] <= n[3] + clk_ticks.ref_tick;
		n[4] <= n[4] + clock_monitor_reset;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : check
	function automatic logic near(input int a, input int b);
		return a - b <= 2 && b - a <= 2;
	endfunction : near
	// zero-wait slave, but the wait loop keeps the master honest
	task automatic apb(input logic [11:0] idx, input logic w,
		input logic [31:0] dw);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[9:0], 2'b00};
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic span(input int c);
		s = n;
		repeat (c) @(posedge pclk);
		foreach (d[i]) d[i] = n[i] - s[i];
	endtask : span
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ri[i]) begin
			apb(ri[i], 1'b0, 32'h0);
			check("reset value", rd, rv[i]);
		end
		apb(12'h2F9, 1'b0, 32'h0);
		check("unmapped", {err, rd[30:0]}, 32'h80000000);
		for (k = 0; k < 10; k++) begin
			r = k == 0 ? 32'h26 : k == 1 ? 32'h27 : $random(seed) & 32'hFF;
			apb(IDX_WRITE_GUARD_BIT, 1'b1, r);
			apb(IDX_WRITE_GUARD_BIT, 1'b0, 32'h0);
			check("guard", rd, r == 32'h26 ? 32'h0 : 32'h1);
		end
		apb(IDX_WRITE_GUARD_BIT, 1'b1, 32'h0);
		apb(IDX_OSC, 1'b1, 32'h9F);
		apb(IDX_SYN, 1'b1, 32'h0);
		apb(IDX_OSC, 1'b0, 32'h0);
		check("guarded osc", rd, 32'h0);
		apb(IDX_SYN, 1'b0, 32'h0);
		check("guarded synth", rd, RST_SYN);
		apb(IDX_WRITE_GUARD_BIT, 1'b1, 32'h26);
		for (k = 0; k < 6; k++) begin
			r = $random(seed) & 32'h7F;
			apb(IDX_OSC, 1'b1, r);
			apb(IDX_OSC, 1'b0, 32'h0);
			check("osc reg", rd, r & 32'h5F);
			check("osc off", osc_enable, 32'h0);
		end
		check("trim out", rc_trim, RST_TRIM);
		check("ready", pready, 32'h1);
		apb(IDX_OSC, 1'b1, 32'h0);
		// lowest multiplier and range codes zero match the slow model
		apb(IDX_SYN, 1'b1, 32'h0);
		apb(IDX_PLL, 1'b1, 32'h10);
		k = 0;
		rd = 32'h0;
		while (rd[FLAG_LOCK] !== 1'b1 && k < 600) begin
			apb(IDX_FLAG, 1'b0, 32'h0);
			k++;
		end
		check("lock", rd[FLAG_LOCK], 32'h1);
		check("lock irq", lock_irq, 32'h1);
		apb(IDX_FLAG, 1'b1, 32'h10);
		@(negedge pclk);
		check("irq cleared", lock_irq, 32'h0);
		for (k = 0; k < 4; k++) begin
			apb(IDX_POST_DIVIDER, 1'b1, k);
			span(960);
			check("pll ratio", near(d[1], d[0] / (k + 1)), 32'h1);
			check("bus ratio", near(d[2], d[1] / 2), 32'h1);
		end
		apb(IDX_POST_DIVIDER, 1'b1, 32'h0);
		apb(IDX_OSC, 1'b1, 32'h0);
		apb(IDX_FLAG, 1'b0, 32'h0);
		check("lock cleared", rd[FLAG_LOCK], 32'h0);
		span(160);
		check("unlocked ratio", near(d[1], d[0] / 4), 32'h1);
		r = $random(seed) & 3;
		apb(IDX_REFERENCE_DIVIDER, 1'b1, r);
		osc_run = 1'b1;
		// half the vco to osc ratio is not whole, so filter off, narrow
		apb(IDX_OSC, 1'b1, 32'h80);
		@(negedge pclk);
		check("osc on", osc_enable, 32'h1);
		// no stop mode here; the wait covers the startup time anyway
		span(960);
		check("ref ratio", near(d[3], d[5] / (r + 1)), 32'h1);
		check("qualified", osc_qualified, 32'h1);
		apb(IDX_CLKS, 1'b1, 32'h0);
		@(negedge pclk);
		check("bus on osc", bus_from_osc, 32'h1);
		apb(IDX_OSC, 1'b1, 32'h1F);
		apb(IDX_OSC, 1'b0, 32'h0);
		check("osc write dropped", rd, 32'h80);
		// stopping the pin is the loss of oscillation
		osc_run = 1'b0;
		span(1300);
		check("monitor reset", d[4] != 0, 32'h1);
		check("back on pll", bus_from_osc, 32'h0);
		apb(IDX_OSC, 1'b1, 32'h0);
		r = ($random(seed) & 32'hFF) | 32'h1;
		apb(IDX_TEST, 1'b1, r);
		apb(IDX_TEST, 1'b0, 32'h0);
		check("test closed", rd, 32'h0);
		special_mode <= 1'b1;
		apb(IDX_TEST, 1'b1, r);
		apb(IDX_TEST, 1'b0, 32'h0);
		check("test open", rd, r);
		check("test out", factory_test, r);
		report_and_stop;
	end
endmodule : opcc_clock_config_tb_top

// ---- opcc_pkg.sv ----
// constants, types and register map of the oscillator and pll clock config
// Summary of operation
// [RL1] oscillator register writable only unguarded, pll selected
// [RL2] accepted oscillator write clears lock and qualified
// [RL3] software zeroes filter ratio for non-integer ratio
// [RL4] enable bit seven selects oscillator reference
// [RL5] lost oscillation raises clock monitor reset
// [RL6] qualified flag gates oscillator clock use
// [RL7] software waits startup time before pseudo stop
// [RL8] bit six picks narrow or wide window
// [RL9] software picks wide window above 25 MHz
// [RL10] zero filter ratio disables filter and qualification
// [RL11] only 0x26 clears guard, other writes set
// [RL12] guard blocks writes to clock configuration; the post divider stays writable while guarded
// [RL13] test register writable only in special mode
// [RL14] reference is oscillator over divider plus one
// [RL15] vco is twice reference times multiplier plus one
// [RL16] pll output is vco over post divider or four
// [RL17] bus clock is half pll output
// [RL18] lock detector compares feedback against reference
// [RL19] lock sets within tolerance, clears beyond unlock tolerance
// [RL20] lock toggle requests interrupt when enabled
// [RL21] software programs range fields to match frequencies
// [RL22] software prefers low ratio and high reference
// [RL23] lost qualification forces pll clock select; a same-cycle oscillator select write wins while pll is selected
// [RL24] post divider resets to 0x03
// [RL25] unused oscillator and guard bits read zero
package opcc_pkg;
	localparam int ADDR_W = 12;
	// register indexes; byte address is four times the index
	localparam logic [11:0] IDX_SYN = 12'h2F0;
	localparam logic [11:0] IDX_REFERENCE_DIVIDER = 12'h2F1;
	localparam logic [11:0] IDX_POST_DIVIDER = 12'h2F2;
	localparam logic [11:0] IDX_CLKS = 12'h2F3;
	localparam logic [11:0] IDX_PLL = 12'h2F4;
	localparam logic [11:0] IDX_FLAG = 12'h2F5;
	localparam logic [11:0] IDX_TRIM = 12'h2F8;
	localparam logic [11:0] IDX_OSC = 12'h2FA;
	localparam logic [11:0] IDX_WRITE_GUARD_BIT = 12'h2FB;
	localparam logic [11:0] IDX_TEST = 12'h2FC;
	// reset values
	localparam logic [7:0] RST_SYN = 8'h5F;
	localparam logic [7:0] RST_REFERENCE_DIVIDER = 8'h00;
	localparam logic [4:0] RST_POST_DIVIDER = 5'h03;
	localparam logic [15:0] RST_TRIM = 16'h0200;
	localparam logic [7:0] RST_TEST = 8'h00;
	// field positions
	localparam int CLKS_PLL_CLOCK_SELECT = 7;
	localparam int PLL_LOCK_IRQ_ENABLE = 4;
	localparam int FLAG_LOCKIF = 4;
	localparam int FLAG_LOCK = 3;
	localparam int FLAG_QUAL = 0;
	localparam int GUARD_BIT = 0;
	localparam logic [7:0] GUARD_KEY = 8'h26;
	localparam logic [4:0] UNLOCKED_DIV = 5'h03;
	// lock detector window, in reference ticks, and tolerances
	localparam int LOCK_WIN = 16;
	localparam int LOCK_TOL = 1;
	localparam int UNL_TOL = 2;
	localparam int QUAL_EDGES = 8;
	// oscillation is lost after this long without an edge
	localparam int CLK_NS = 100;
	localparam int MON_TIME_NS = 100000;
	localparam int MON_CYCLES = MON_TIME_NS / CLK_NS;

	typedef struct packed {
		logic enable;
		logic window_wide;
		logic unused;
		logic [4:0] ratio;
	} opcc_osc_t;

	typedef struct packed {
		logic ref_tick;
		logic fb_tick;
		logic vco_tick;
		logic pll_tick;
		logic bus_tick;
	} opcc_ticks_t;
endpackage : opcc_pkg

// ---- opcc_tick_div.sv ----
// divides a stream of one-cycle ticks by a programmable count plus one
`timescale 1ns/1ps
module opcc_tick_div #(
	parameter int W = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [W-1:0] div,
	output logic tick_out
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_tick_out;

	initial begin
		if (W < 1 || W > 16) begin
			$error("opcc_tick_div: W out of range");
		end
	end

	always_comb begin
		next_cnt = cnt;
		next_tick_out = 1'b0;
		if (clr) begin
			next_cnt = '0;
		end else if (tick_in) begin
			if (cnt >= div) begin
				next_cnt = '0;
				next_tick_out = 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_out <= next_tick_out;
		end
	end
endmodule : opcc_tick_div
